// >>> shared/rtc_map.svh
// Purpose: Register offsets, field masks, bit positions and reset values
// Assumes: Sixteen byte-wide registers on a four-bit register address
// Notes: Masks mark the implemented bits of the time, date and alarm registers that have unused bits
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
`define A_SEC 4'h0
`define A_MIN 4'h1
`define A_HOUR 4'h2
`define A_WDAY 4'h3
`define A_MDAY 4'h4
`define A_MON 4'h5
`define A_YEAR 4'h6
`define A_TRIM 4'h7
`define A_WAMIN 4'h8
`define A_WAHOUR 4'h9
`define A_WADAYS 4'ha
`define A_DAMIN 4'hb
`define A_DAHOUR 4'hc
`define A_UNUSED 4'hd
`define A_CTL1 4'he
`define A_CTL2 4'hf
`define M_MINSEC 8'h7f
`define M_HOUR 8'h3f
`define M_WDAY 8'h07
`define M_MDAY 8'h3f
`define M_MON 8'h9f
`define M_WADAYS 8'h7f
`define CTL_RESET 8'h00
`define B_WEEKLY_ALARM_ENABLE 7
`define B_DAILY_ALARM_ENABLE 6
`define B_HOUR24 5
`define B_SPARE_B 4
`define B_TEST 3
`define B_THRESHOLD_SELECT 7
`define B_VDET 6
`define B_XST 5
`define B_PON 4
`define B_SPARE_A 3
`define B_PERIODIC_FLAG 2
`define B_WEEKLY_ALARM_FLAG 1
`define B_DAILY_ALARM_FLAG 0
`define TICKS_PER_SEC_DEF 4
`endif

// >>> shared/rtc_pkg.sv
// Purpose: Types shared by the clock register map
// Assumes: Nothing beyond the map header
// Notes: Periodic select codes as stored in the low three control bits
`default_nettype none
package rtc_pkg;
  typedef enum logic [2:0] {
    PER_OFF = 3'h0,
    PER_LOW = 3'h1,
    PER_2HZ = 3'h2,
    PER_1HZ = 3'h3,
    PER_SEC = 3'h4,
    PER_MIN = 3'h5,
    PER_HOUR = 3'h6,
    PER_MONTH = 3'h7
  } periodic_mode_t;
endpackage
`default_nettype wire

// >>> logic/rtc_regmap.sv
// Purpose: Register map, BCD time and calendar, alarms and control bits
// Assumes: Register port driven by a serial engine on clk; pins are async
// Notes: One rising edge of tickPin is one sub-second step
`default_nettype none
`include "rtc_map.svh"
module rtc_regmap
  import rtc_pkg::*;
#(
  parameter int TICKS_PER_SEC = `TICKS_PER_SEC_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [3:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic tickPin,
  input wire logic powerUpPin,
  input wire logic oscHaltPin,
  input wire logic voltLowPin,
  output logic irqOutN
);
  // Refuse divider counts that the sub-second logic cannot serve
  if (TICKS_PER_SEC < 4 || TICKS_PER_SEC > 256 ||
      TICKS_PER_SEC % 4 != 0) begin : badTicks
    $error("TICKS_PER_SEC must be a multiple of 4 from 4 to 256");
  end

  localparam logic [7:0] TPS = 8'(TICKS_PER_SEC);
  localparam logic [7:0] HALF = 8'(TICKS_PER_SEC / 2);
  localparam logic [7:0] QUART = 8'(TICKS_PER_SEC / 4);

  logic [7:0] sec, min, hour, wday, mday, mon, year, trim;
  logic [7:0] waMin, waHour, waDays, daMin, daHour, ctl1, ctl2;
  logic [7:0] subCount;
  logic [2:0] tickSync;
  logic [1:0] pwrSync, haltSync, lowSync;
  logic secEvt, minEvt, hourEvt, monEvt;

  // BCD step of a packed byte
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // Two-stage synchronisers; the tick keeps a third stage for its edge
  always_ff @(posedge clk) begin
    if (reset) begin
      tickSync <= 3'h0;
      pwrSync <= 2'h0;
      haltSync <= 2'h0;
      lowSync <= 2'h0;
    end else if (ce) begin
      tickSync <= {tickSync[1:0], tickPin};
      pwrSync <= {pwrSync[0], powerUpPin};
      haltSync <= {haltSync[0], oscHaltPin};
      lowSync <= {lowSync[0], voltLowPin};
    end
  end

  // Only second stages, and the tick's third stage, feed logic; a first stage may still be settling
  wire tickEdge = tickSync[1] & ~tickSync[2];
  wire powerUp = pwrSync[1];
  wire oscHalt = haltSync[1];
  wire voltLow = lowSync[1];

  // Host write decode
  wire wrSec = regWrite && regAddr == `A_SEC;
  wire wrMin = regWrite && regAddr == `A_MIN;
  wire wrHour = regWrite && regAddr == `A_HOUR;
  wire wrWday = regWrite && regAddr == `A_WDAY;
  wire wrMday = regWrite && regAddr == `A_MDAY;
  wire wrMon = regWrite && regAddr == `A_MON;
  wire wrYear = regWrite && regAddr == `A_YEAR;
  wire wrTime = wrSec | wrMin | wrHour | wrWday | wrMday | wrMon | wrYear;
  wire wrCtl1 = regWrite && regAddr == `A_CTL1;
  wire wrCtl2 = regWrite && regAddr == `A_CTL2;
  wire power_up_flag = ctl2[`B_PON];

  // Sub-second divider; a seconds write restarts it
  wire lastSub = subCount == TPS - 8'h01;
  wire secStrobe = tickEdge && lastSub && !wrTime;

  // Rollover chain
  wire secWrap = sec == 8'h59;
  wire minWrap = secWrap && min == 8'h59;
  wire hour24 = ctl1[`B_HOUR24];
  wire [3:0] yTens = year[7:4];
  wire [3:0] yUnits = year[3:0];
  wire [6:0] yearBin = 7'({yTens, 3'h0} + {yTens, 1'h0} + {3'h0, yUnits});
  wire leap = yearBin[1:0] == 2'h0;
  wire [4:0] monNum = mon[4:0];
  wire short30 = monNum == 5'h04 || monNum == 5'h06 || monNum == 5'h09 ||
                 monNum == 5'h11;
  wire [7:0] monLen = (monNum == 5'h02) ? (leap ? 8'h29 : 8'h28) :
                      (short30 ? 8'h30 : 8'h31);
  wire hourWrap = hour24 ? hour == 8'h23 : hour == 8'h31;
  wire dayWrap = minWrap && hourWrap && mday == monLen;
  wire monWrap = dayWrap && monNum == 5'h12;
  wire yearWrap = monWrap && year == 8'h99;

  // Hour stepping in both modes, PM marker in bit 5
  wire [7:0] hour12Next = (hour == 8'h11) ? 8'h32 :
                          (hour == 8'h31) ? 8'h12 :
                          (hour == 8'h12) ? 8'h01 :
                          (hour == 8'h32) ? 8'h21 : bcdInc(hour);
  wire [7:0] hour24Next = hourWrap ? 8'h00 : bcdInc(hour);
  wire [7:0] hourNext = hour24 ? hour24Next : hour12Next;
  wire [7:0] wdayNext = (wday >= 8'h06) ? 8'h00 : wday + 8'h01;
  wire [7:0] mdayNext = (mday == monLen) ? 8'h01 : bcdInc(mday);
  wire [7:0] monInc = bcdInc(mon);
  wire [7:0] monNext = {mon[7] ^ yearWrap, 2'h0,
                        (monNum == 5'h12) ? 5'h01 : monInc[4:0]};

  // Divider and time counters; a host write replaces the count
  always_ff @(posedge clk) begin
    if (reset) begin
      subCount <= 8'h00;
      sec <= 8'h00;
      min <= 8'h00;
      hour <= 8'h12;
      wday <= 8'h00;
      mday <= 8'h01;
      mon <= 8'h01;
      year <= 8'h00;
    end else if (ce) begin
      if (wrSec)
        subCount <= 8'h00;
      else if (tickEdge)
        subCount <= lastSub ? 8'h00 : subCount + 8'h01;
      if (wrSec) sec <= regWrData & `M_MINSEC;
      else if (secStrobe) sec <= secWrap ? 8'h00 : bcdInc(sec);
      if (wrMin) min <= regWrData & `M_MINSEC;
      else if (secStrobe && secWrap) min <= minWrap ? 8'h00 : bcdInc(min);
      if (wrHour) hour <= regWrData & `M_HOUR;
      else if (secStrobe && minWrap) hour <= hourNext;
      if (wrWday) wday <= regWrData & `M_WDAY;
      else if (secStrobe && minWrap && hourWrap) wday <= wdayNext;
      if (wrMday) mday <= regWrData & `M_MDAY;
      else if (secStrobe && minWrap && hourWrap) mday <= mdayNext;
      if (wrMon) mon <= regWrData & `M_MON;
      else if (secStrobe && dayWrap) mon <= monNext;
      if (wrYear) year <= regWrData;
      else if (secStrobe && monWrap) year <= yearWrap ? 8'h00 : bcdInc(year);
    end
  end

  // Event pulses registered on the same edge as the counters move
  always_ff @(posedge clk) begin
    if (reset) begin
      secEvt <= 1'b0;
      minEvt <= 1'b0;
      hourEvt <= 1'b0;
      monEvt <= 1'b0;
    end else if (ce) begin
      secEvt <= secStrobe;
      minEvt <= secStrobe && secWrap;
      hourEvt <= secStrobe && minWrap;
      monEvt <= secStrobe && dayWrap;
    end
  end

  // Alarm stores; weekday alarm bit n selects weekday n
  always_ff @(posedge clk) begin
    if (reset) begin
      waMin <= 8'h00;
      waHour <= 8'h00;
      waDays <= 8'h00;
      daMin <= 8'h00;
      daHour <= 8'h00;
    end else if (ce && regWrite) begin
      if (regAddr == `A_WAMIN) waMin <= regWrData & `M_MINSEC;
      if (regAddr == `A_WAHOUR) waHour <= regWrData & `M_HOUR;
      if (regAddr == `A_WADAYS) waDays <= regWrData & `M_WADAYS;
      if (regAddr == `A_DAMIN) daMin <= regWrData & `M_MINSEC;
      if (regAddr == `A_DAHOUR) daHour <= regWrData & `M_HOUR;
    end
  end

  // Match is checked only at a new minute, gated by the enables
  wire wMatch = min == waMin && hour == waHour && waDays[wday[2:0]];
  wire dMatch = min == daMin && hour == daHour;
  wire wAlarmSet = minEvt && ctl1[`B_WEEKLY_ALARM_ENABLE] && wMatch;
  wire dAlarmSet = minEvt && ctl1[`B_DAILY_ALARM_ENABLE] && dMatch;
  periodic_mode_t perMode;
  assign perMode = periodic_mode_t'(ctl1[2:0]);
  wire perLevel = ctl1[2];
  wire perEvt = (perMode == PER_SEC && secEvt) ||
                (perMode == PER_MIN && minEvt) ||
                (perMode == PER_HOUR && hourEvt) ||
                (perMode == PER_MONTH && monEvt);

  // Host clears of sticky bits: writing 0 clears, writing 1 is ignored
  wire clrVdet = wrCtl2 && !regWrData[`B_VDET];
  wire clrPon = wrCtl2 && !regWrData[`B_PON];
  wire clrCtfg = wrCtl2 && !regWrData[`B_PERIODIC_FLAG];
  wire clrWafg = wrCtl2 && !regWrData[`B_WEEKLY_ALARM_FLAG];
  wire clrDafg = wrCtl2 && !regWrData[`B_DAILY_ALARM_FLAG];

  // Trim and control one; power-up flag holds them at zero while set
  always_ff @(posedge clk) begin
    if (reset) begin
      trim <= `CTL_RESET;
      ctl1 <= `CTL_RESET;
    end else if (ce) begin
      if (power_up_flag) begin
        trim <= `CTL_RESET;
        ctl1 <= `CTL_RESET;
      end else begin
        if (regWrite && regAddr == `A_TRIM) trim <= regWrData;
        if (wrCtl1) ctl1 <= regWrData;
      end
    end
  end

  // Control two; hardware events win over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl2 <= `CTL_RESET;
      ctl2[`B_PON] <= 1'b1;
    end else if (ce) begin
      if (powerUp) ctl2[`B_PON] <= 1'b1;
      else if (clrPon) ctl2[`B_PON] <= 1'b0;
      if (oscHalt) ctl2[`B_XST] <= 1'b0;
      else if (wrCtl2) ctl2[`B_XST] <= regWrData[`B_XST];
      if (power_up_flag || powerUp) begin
        ctl2[`B_THRESHOLD_SELECT] <= 1'b0;
        ctl2[`B_VDET] <= 1'b0;
        ctl2[`B_SPARE_A] <= 1'b0;
        ctl2[2:0] <= 3'h0;
      end else begin
        if (wrCtl2) ctl2[`B_THRESHOLD_SELECT] <= regWrData[`B_THRESHOLD_SELECT];
        if (wrCtl2) ctl2[`B_SPARE_A] <= regWrData[`B_SPARE_A];
        if (voltLow) ctl2[`B_VDET] <= 1'b1;
        else if (clrVdet) ctl2[`B_VDET] <= 1'b0;
        if (perEvt) ctl2[`B_PERIODIC_FLAG] <= 1'b1;
        else if (clrCtfg) ctl2[`B_PERIODIC_FLAG] <= 1'b0;
        if (wAlarmSet) ctl2[`B_WEEKLY_ALARM_FLAG] <= 1'b1;
        else if (clrWafg) ctl2[`B_WEEKLY_ALARM_FLAG] <= 1'b0;
        if (dAlarmSet) ctl2[`B_DAILY_ALARM_FLAG] <= 1'b1;
        else if (clrDafg) ctl2[`B_DAILY_ALARM_FLAG] <= 1'b0;
      end
    end
  end

  // Periodic output; pulse modes fall with the seconds step
  wire lowHalf = subCount < HALF;
  wire lowQuarter = (subCount % HALF) < QUART;
  wire perLow = (perMode == PER_LOW) ||
                (perMode == PER_2HZ && lowQuarter) ||
                (perMode == PER_1HZ && lowHalf) ||
                (perLevel && ctl2[`B_PERIODIC_FLAG]);
  wire irqLow = perLow || (ctl1[`B_WEEKLY_ALARM_ENABLE] && ctl2[`B_WEEKLY_ALARM_FLAG]) ||
                (ctl1[`B_DAILY_ALARM_ENABLE] && ctl2[`B_DAILY_ALARM_FLAG]);

  // Read mux; location D and unused bits read zero
  logic [7:0] rdSel;
  always_comb begin
    case (regAddr)
      `A_SEC: rdSel = sec;
      `A_MIN: rdSel = min;
      `A_HOUR: rdSel = hour;
      `A_WDAY: rdSel = wday;
      `A_MDAY: rdSel = mday;
      `A_MON: rdSel = mon;
      `A_YEAR: rdSel = year;
      `A_TRIM: rdSel = trim;
      `A_WAMIN: rdSel = waMin;
      `A_WAHOUR: rdSel = waHour;
      `A_WADAYS: rdSel = waDays;
      `A_DAMIN: rdSel = daMin;
      `A_DAHOUR: rdSel = daHour;
      `A_CTL1: rdSel = ctl1;
      `A_CTL2: rdSel = ctl2;
      default: rdSel = 8'h00;
    endcase
  end

  // Registered read data and interrupt pin; pin idles high
  always_ff @(posedge clk) begin
    if (reset) begin
      regRdData <= 8'h00;
      irqOutN <= 1'b1;
    end else if (ce) begin
      regRdData <= rdSel;
      irqOutN <= !(irqLow && !power_up_flag);
    end
  end
endmodule
`default_nettype wire

// >>> testbench/rtc_regmap_asserts.sv
// Purpose: Port-level checks on the clock register map
// Assumes: Sees only the top module ports, one clock domain
// Notes: Bound to the design at the foot of this file
`default_nettype none
`include "rtc_map.svh"
module rtc_regmap_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [3:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic tickPin,
  input wire logic powerUpPin,
  input wire logic oscHaltPin,
  input wire logic voltLowPin,
  input wire logic irqOutN
);
  // Read data lags the address by one enabled cycle
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  reset_idle_a: assert property (
    $fell(reset) |-> regRdData == 8'h00 && irqOutN
  ) else $error("read data or pin busy after reset");
  unused_zero_a: assert property (
    ce && regAddr == `A_UNUSED |=> regRdData == 8'h00
  ) else $error("unused location reads nonzero");
  weekday_mask_a: assert property (
    ce && regAddr == `A_WDAY |=> regRdData[7:3] == 5'h00
  ) else $error("weekday upper bits not zero");
  hour_bcd_a: assert property (
    ce && regAddr == `A_HOUR |=> regRdData[7:6] == 2'h0 &&
      regRdData[3:0] <= 4'h9
  ) else $error("hour not packed BCD");
  second_bcd_a: assert property (
    ce && regAddr == `A_SEC |=> !regRdData[7] && regRdData[3:0] <= 4'h9
  ) else $error("seconds not packed BCD");
  write_read_a: assert property (
    ce && regWrite && regAddr == `A_DAHOUR ##1
      ce && !regWrite && regAddr == `A_DAHOUR |=>
      regRdData == ($past(regWrData, 2) & `M_HOUR)
  ) else $error("alarm hour readback wrong");
  pon_quiet_a: assert property (
    (ce && powerUpPin)[*6] |=> irqOutN
  ) else $error("interrupt pin active during power-up");
  pon_clear_a: assert property (
    (ce && powerUpPin)[*6] ##0 regAddr inside {`A_TRIM, `A_CTL1} |=>
      regRdData == `CTL_RESET
  ) else $error("control or trim not cleared by power-up");
endmodule
bind rtc_regmap rtc_regmap_asserts rtc_regmap_asserts_i (
  .clk(clk), .reset(reset), .ce(ce), .regAddr(regAddr),
  .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
  .tickPin(tickPin), .powerUpPin(powerUpPin), .oscHaltPin(oscHaltPin),
  .voltLowPin(voltLowPin), .irqOutN(irqOutN)
);
`default_nettype wire

// >>> testbench/rtc_host_model.sv
// Purpose: Host side of the register port
// Assumes: Requests change just after a rising clock edge
// Notes: Write data is inverted once released so stale data never matches
`default_nettype none
module rtc_host_model (
  input wire logic clk,
  input wire logic [7:0] regRdData,
  output logic [3:0] regAddr,
  output logic regWrite,
  output logic [7:0] regWrData
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    regAddr = 4'h0;
    regWrite = 1'b0;
    regWrData = 8'h00;
  end
  // One-cycle write strobe with address and data held across it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrite <= 1'b1;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regWrData <= ~d;
  endtask
  // Registered read data is settled one edge after the address
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    repeat (2) @(posedge clk);
    #1 d = regRdData;
  endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the clock register map
// Assumes: Four sub-second ticks make one second
// Notes: Enable and status pins idle outside the scenarios that drive them
`default_nettype none
`include "rtc_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, tickPin, powerUpPin, regWrite, irqOutN;
  logic ce, oscHaltPin, voltLowPin;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData;
  int n_fail, n_checks, cycles;
  rtc_regmap #(.TICKS_PER_SEC(4)) rtc_regmap_i (
    .clk(clk), .reset(reset), .ce(ce), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
    .tickPin(tickPin), .powerUpPin(powerUpPin), .oscHaltPin(oscHaltPin),
    .voltLowPin(voltLowPin), .irqOutN(irqOutN)
  );
  rtc_host_model rtc_host_model_i (
    .clk(clk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData)
  );
  // Free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard: the tests need well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    rtc_host_model_i.wr(a, d);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rtc_host_model_i.rd(a, v);
    check(v, e);
  endtask
  // Pin period 320 ns: high four cycles, low four
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      tickPin <= 1'b1;
      repeat (4) @(posedge clk);
      tickPin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic t_reset();
    rc(`A_CTL2, 8'h10);
    rc(`A_CTL1, `CTL_RESET);
    wr(`A_CTL1, 8'hff);
    rc(`A_CTL1, 8'h00);
    wr(`A_CTL2, 8'h10);
    rc(`A_CTL2, 8'h10);
    wr(`A_CTL2, 8'h00);
    rc(`A_CTL2, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_fields();
    wr(`A_CTL1, 8'hf8);
    rc(`A_CTL1, 8'hf8);
    wr(`A_TRIM, 8'hff);
    rc(`A_TRIM, 8'hff);
    wr(`A_TRIM, 8'h05);
    rc(`A_TRIM, 8'h05);
    for (int i = 0; i < 8; i++) begin
      wr(`A_CTL1, {5'h00, 3'(i)});
      rc(`A_CTL1, {5'h00, 3'(i)});
      // No tick yet, so both pulse modes sit in their low phase
      check({7'h00, irqOutN}, 8'(i == 0 || i > 3));
    end
    wr(`A_UNUSED, 8'hff);
    rc(`A_UNUSED, 8'h00);
    wr(`A_WDAY, 8'hff);
    rc(`A_WDAY, 8'h07);
    $display("field test done");
  endtask
  task automatic t_hours();
    wr(`A_CTL1, 8'h00);
    wr(`A_HOUR, 8'h11);
    wr(`A_MIN, 8'h59);
    wr(`A_SEC, 8'h59);
    tick(4);
    rc(`A_HOUR, 8'h32);
    rc(`A_MIN, 8'h00);
    wr(`A_DAHOUR, 8'hff);
    rc(`A_DAHOUR, 8'h3f);
    wr(`A_DAHOUR, 8'h00);
    wr(`A_DAMIN, 8'h00);
    wr(`A_CTL1, 8'h60);
    wr(`A_HOUR, 8'h23);
    wr(`A_MIN, 8'h59);
    wr(`A_SEC, 8'h59);
    tick(4);
    rc(`A_HOUR, 8'h00);
    check({7'h00, irqOutN}, 8'h00);
    rc(`A_CTL2, 8'h01);
    $display("hour test done");
  endtask
  // Level mode, frozen enable, then the halt and low-voltage pins
  task automatic t_events();
    wr(`A_CTL2, 8'h00);
    wr(`A_CTL1, 8'h24);
    wr(`A_SEC, 8'h10);
    tick(4);
    rc(`A_SEC, 8'h11);
    rc(`A_CTL2, 8'h04);
    check({7'h00, irqOutN}, 8'h00);
    wr(`A_CTL2, 8'ha8);
    rc(`A_CTL2, 8'ha8);
    check({7'h00, irqOutN}, 8'h01);
    @(posedge clk);
    ce <= 1'b0;
    tick(4);
    ce <= 1'b1;
    rc(`A_SEC, 8'h11);
    @(posedge clk);
    oscHaltPin <= 1'b1;
    repeat (3) @(posedge clk);
    oscHaltPin <= 1'b0;
    voltLowPin <= 1'b1;
    repeat (3) @(posedge clk);
    voltLowPin <= 1'b0;
    rc(`A_CTL2, 8'hc8);
    wr(`A_CTL2, 8'h88);
    rc(`A_CTL2, 8'h88);
    $display("event test done");
  endtask
  // Power-up must clear control bits but keep the oscillation monitor
  task automatic t_pon();
    wr(`A_CTL2, 8'h20);
    rc(`A_CTL2, 8'h20);
    wr(`A_CTL1, 8'h71);
    rc(`A_CTL1, 8'h71);
    check({7'h00, irqOutN}, 8'h00);
    @(posedge clk);
    powerUpPin <= 1'b1;
    repeat (8) @(posedge clk);
    powerUpPin <= 1'b0;
    repeat (2) @(posedge clk);
    check({7'h00, irqOutN}, 8'h01);
    rc(`A_CTL1, 8'h00);
    rc(`A_TRIM, 8'h00);
    rc(`A_CTL2, 8'h30);
    $display("power-up test done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Reset held for 16 cycles, then the tests in order
  initial begin
    reset = 1'b1;
    tickPin = 1'b0;
    powerUpPin = 1'b0;
    ce = 1'b1;
    oscHaltPin = 1'b0;
    voltLowPin = 1'b0;
    n_fail = 0;
    n_checks = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_fields();
    t_hours();
    t_events();
    t_pon();
    finish_test();
  end
endmodule
`default_nettype wire
